/* File: logic/lcu_link_ctrl.sv */
// module: upper fields of the link control register with bandwidth interrupts
module lcu_link_ctrl
  import lcu_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  input  wire logic        upstream_i,
  input  wire logic        bw_notify_capable_i,
  input  wire logic        retrain_done_i,
  input  wire logic        link_down_i,
  input  wire logic        autonomous_change_i,
  input  wire logic        ltssm_l0s_exit_i,
  input  wire logic        ltssm_recovery_i,
  input  wire logic        unreliable_i,
  input  wire logic        width_reconfig_i,
  output logic             extra_ordered_set_enable_o,
  output logic             send_extra_sets_o,
  output logic             width_reduce_o,
  output logic             width_reconfig_o,
  output logic             bw_mgmt_irq_o,
  output logic             autonomous_bw_irq_o,
  output logic             irq_o
);

  logic       extra_os_ff;
  logic       bwie_ff;
  logic       abwie_ff;
  logic       bwst_ff;
  logic       abwst_ff;
  logic [1:0] ist_ff;
  logic [1:0] imsk_ff;
  logic       bwie_ok;
  logic       bwst_ok;
  logic       ctrl_wr;
  logic       st_wr;
  logic       ist_wr;
  logic [1:0] req;
  logic [1:0] req_q_ff;
  logic [15:0] nxt_rdata;
  logic [15:0] ctrl_view;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    return a == r;
  endfunction

  assign ctrl_wr = wr_i && hit(addr_i, LCU_ADDR_CTRL);
  assign st_wr   = wr_i && hit(addr_i, LCU_ADDR_STATUS);
  assign ist_wr  = wr_i && hit(addr_i, LCU_ADDR_IRQ_ST);
  assign bwie_ok = bw_notify_capable_i && !upstream_i;
  assign bwst_ok = bwie_ok;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      extra_os_ff <= LCU_CTRL_RESET[LCU_BIT_EXTRA_OS];
    end else if (ctrl_wr) begin
      extra_os_ff <= wdata_i[LCU_BIT_EXTRA_OS];
    end
  end

  a_extra_wr: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_wr |=> extra_ordered_set_enable_o == $past(wdata_i[LCU_BIT_EXTRA_OS]))
    else $error("extra set control not written");

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bwie_ff  <= LCU_CTRL_RESET[LCU_BIT_BWIE];
      abwie_ff <= LCU_CTRL_RESET[LCU_BIT_ABWIE];
    end else if (!bwie_ok) begin
      bwie_ff  <= 1'b0;
      abwie_ff <= 1'b0;
    end else if (ctrl_wr) begin
      bwie_ff  <= wdata_i[LCU_BIT_BWIE];
      abwie_ff <= wdata_i[LCU_BIT_ABWIE];
    end
  end

  a_en_capable: assert property (@(posedge clk_i) disable iff (rst_i)
    !bw_notify_capable_i |=> !bwie_ff && !abwie_ff)
    else $error("enable set without capability");
  a_en_upstream: assert property (@(posedge clk_i) disable iff (rst_i)
    upstream_i ##1 upstream_i |-> !bwie_ff && !abwie_ff && !bw_mgmt_irq_o)
    else $error("upstream enable set");

  // set on retrain or autonomous change without link down, w1c, set wins
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bwst_ff  <= 1'b0;
      abwst_ff <= 1'b0;
    end else if (!bwst_ok) begin
      bwst_ff  <= 1'b0;
      abwst_ff <= 1'b0;
    end else begin
      if (retrain_done_i && !link_down_i) begin
        bwst_ff <= 1'b1;
      end else if (st_wr && wdata_i[LCU_BIT_BWST]) begin
        bwst_ff <= 1'b0;
      end
      if (autonomous_change_i && !link_down_i) begin
        abwst_ff <= 1'b1;
      end else if (st_wr && wdata_i[LCU_BIT_ABWST]) begin
        abwst_ff <= 1'b0;
      end
    end
  end

  a_st_w1c: assert property (@(posedge clk_i) disable iff (rst_i)
    st_wr && wdata_i[LCU_BIT_BWST] && !retrain_done_i |=> !bwst_ff)
    else $error("status not cleared");
  a_abst_w1c: assert property (@(posedge clk_i) disable iff (rst_i)
    st_wr && wdata_i[LCU_BIT_ABWST] && !autonomous_change_i |=> !abwst_ff)
    else $error("autonomous status not cleared");
  a_st_set: assert property (@(posedge clk_i) disable iff (rst_i)
    retrain_done_i && !link_down_i && bw_notify_capable_i && !upstream_i |=> bwst_ff)
    else $error("status not set after retrain");
  a_abst_set: assert property (@(posedge clk_i) disable iff (rst_i)
    autonomous_change_i && !link_down_i && bw_notify_capable_i && !upstream_i |=> abwst_ff)
    else $error("autonomous status not set");
  a_st_link_down: assert property (@(posedge clk_i) disable iff (rst_i)
    !bwst_ff && link_down_i |=> !bwst_ff)
    else $error("status set through link down");
  a_st_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    bwst_ff && !st_wr && bw_notify_capable_i && !upstream_i |=> bwst_ff)
    else $error("status lost without clear");
  a_st_capable: assert property (@(posedge clk_i) disable iff (rst_i)
    !bw_notify_capable_i |=> !bwst_ff && !abwst_ff)
    else $error("status set without capability");
  a_st_upstream: assert property (@(posedge clk_i) disable iff (rst_i)
    upstream_i |=> !bwst_ff && !abwst_ff && !autonomous_bw_irq_o)
    else $error("upstream status set");

  assign req[LCU_IRQ_BW]  = bwst_ff && bwie_ff;
  assign req[LCU_IRQ_ABW] = abwst_ff && abwie_ff;
  assign bw_mgmt_irq_o       = req[LCU_IRQ_BW];
  assign autonomous_bw_irq_o = req[LCU_IRQ_ABW];

  a_bw_irq_rise: assert property (@(posedge clk_i) disable iff (rst_i)
    bwie_ff && retrain_done_i && !link_down_i ##1 bwie_ff |-> bw_mgmt_irq_o)
    else $error("bw irq missing");
  a_abw_irq_rise: assert property (@(posedge clk_i) disable iff (rst_i)
    abwie_ff && autonomous_change_i && !link_down_i ##1 abwie_ff |-> autonomous_bw_irq_o)
    else $error("abw irq missing");
  a_req_level: assert property (@(posedge clk_i) disable iff (rst_i)
    !bwst_ff || !bwie_ff |-> !bw_mgmt_irq_o)
    else $error("request without cause");
  a_bw_req_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    st_wr && wdata_i[LCU_BIT_BWST] && !retrain_done_i |=> !bw_mgmt_irq_o)
    else $error("bw request stays after clear");
  a_abw_req_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    st_wr && wdata_i[LCU_BIT_ABWST] && !autonomous_change_i |=> !autonomous_bw_irq_o)
    else $error("abw request stays after clear");
  a_en_off_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_wr && !wdata_i[LCU_BIT_BWIE] |=> !bw_mgmt_irq_o)
    else $error("bw request stays after disable");

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      req_q_ff <= LCU_IRQ_RESET;
    end else begin
      req_q_ff <= req;
    end
  end

  // sticky interrupt status on request rise, set wins over clear
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ist_ff <= LCU_IRQ_RESET;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (req[i] && !req_q_ff[i]) begin
          ist_ff[i] <= 1'b1;
        end else if (ist_wr && wdata_i[i]) begin
          ist_ff[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      imsk_ff <= LCU_IRQ_RESET;
    end else if (wr_i && hit(addr_i, LCU_ADDR_IRQ_MSK)) begin
      imsk_ff <= wdata_i[1:0];
    end
  end

  assign irq_o = |(ist_ff & imsk_ff);

  a_ist_set: assert property (@(posedge clk_i) disable iff (rst_i)
    req[LCU_IRQ_BW] && !req_q_ff[LCU_IRQ_BW] |=> ist_ff[LCU_IRQ_BW])
    else $error("bw sticky bit not set");
  a_ist_abw_set: assert property (@(posedge clk_i) disable iff (rst_i)
    req[LCU_IRQ_ABW] && !req_q_ff[LCU_IRQ_ABW] |=> ist_ff[LCU_IRQ_ABW])
    else $error("abw sticky bit not set");

  assign extra_ordered_set_enable_o = extra_os_ff;
  assign send_extra_sets_o = extra_os_ff && (ltssm_l0s_exit_i || ltssm_recovery_i);
  assign width_reduce_o = unreliable_i;
  assign width_reconfig_o = width_reconfig_i;

  a_extra_recovery: assert property (@(posedge clk_i) disable iff (rst_i)
    ltssm_recovery_i && extra_os_ff |-> send_extra_sets_o)
    else $error("extra sets missing");
  a_extra_l0s: assert property (@(posedge clk_i) disable iff (rst_i)
    ltssm_l0s_exit_i && extra_ordered_set_enable_o |-> send_extra_sets_o)
    else $error("extra sets missing on exit");
  a_extra_off: assert property (@(posedge clk_i) disable iff (rst_i)
    !extra_ordered_set_enable_o |-> !send_extra_sets_o)
    else $error("extra sets while disabled");
  a_width_rel: assert property (@(posedge clk_i) disable iff (rst_i)
    width_reduce_o |-> unreliable_i)
    else $error("autonomous width change");
  a_reconfig_pass: assert property (@(posedge clk_i) disable iff (rst_i)
    width_reconfig_o == width_reconfig_i)
    else $error("width reconfiguration blocked");

  always_comb begin
    ctrl_view = 16'h0000;
    ctrl_view[LCU_BIT_EXTRA_OS] = extra_os_ff;
    ctrl_view[LCU_BIT_CLKPM] = 1'b0;
    ctrl_view[LCU_BIT_AWD]   = 1'b0;
    ctrl_view[LCU_BIT_BWIE]  = bwie_ff;
    ctrl_view[LCU_BIT_ABWIE] = abwie_ff;
  end

  always_comb begin
    nxt_rdata = 16'h0000;
    if (rd_i) begin
      unique case (addr_i)
        LCU_ADDR_CTRL:    nxt_rdata = ctrl_view;
        LCU_ADDR_STATUS: begin
          nxt_rdata[LCU_BIT_BWST]  = bwst_ff;
          nxt_rdata[LCU_BIT_ABWST] = abwst_ff;
        end
        LCU_ADDR_IRQ_ST:  nxt_rdata[1:0] = ist_ff;
        LCU_ADDR_IRQ_MSK: nxt_rdata[1:0] = imsk_ff;
        default:          nxt_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 16'h0000;
    end else begin
      rdata_o <= nxt_rdata;
    end
  end

  a_clkpm_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(rd_i) && $past(addr_i) == LCU_ADDR_CTRL |-> !rdata_o[LCU_BIT_CLKPM])
    else $error("clock pm field not zero");
  a_awd_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(rd_i) && $past(addr_i) == LCU_ADDR_CTRL |-> !rdata_o[LCU_BIT_AWD])
    else $error("width disable field not zero");

endmodule

/* File: logic/lcu_pkg.sv */
// package: link control upper field layout, offsets and interrupt layout
package lcu_pkg;
  localparam logic [3:0]  LCU_ADDR_CTRL    = 4'h0;
  localparam logic [3:0]  LCU_ADDR_STATUS  = 4'h4;
  localparam logic [3:0]  LCU_ADDR_IRQ_ST  = 4'h8;
  localparam logic [3:0]  LCU_ADDR_IRQ_MSK = 4'hc;
  localparam int          LCU_BIT_EXTRA_OS = 7;
  localparam int          LCU_BIT_CLKPM    = 8;
  localparam int          LCU_BIT_AWD      = 9;
  localparam int          LCU_BIT_BWIE     = 10;
  localparam int          LCU_BIT_ABWIE    = 11;
  localparam int          LCU_BIT_BWST     = 14;
  localparam int          LCU_BIT_ABWST    = 15;
  localparam logic [15:0] LCU_CTRL_RESET   = 16'h0000;
  localparam logic [1:0]  LCU_IRQ_RESET    = 2'h0;
  localparam int          LCU_IRQ_BW       = 0;
  localparam int          LCU_IRQ_ABW      = 1;
endpackage

/* File: verification/lcu_link_ctrl_tb_top.sv */
// testbench: register access and event checks for the link control upper fields
module lcu_link_ctrl_tb_top import lcu_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [3:0]  addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic        wr_i = 1'b0, rd_i = 1'b0, up_i = 1'b0, cap_i = 1'b1;
  logic        rtr_i = 1'b0, ldn_i = 1'b0, aut_i = 1'b0, l0s_i = 1'b0, rec_i = 1'b0;
  logic        unr_i = 1'b0, wrc_i = 1'b0;
  logic [15:0] rdata;
  logic        eos, sxs, wred, wrec, bwirq, abwirq, irq;
  int          num_errors = 0;
  int          tests_run = 0;
  int          cycles = 0;

  lcu_link_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .upstream_i(up_i),
    .bw_notify_capable_i(cap_i), .retrain_done_i(rtr_i), .link_down_i(ldn_i),
    .autonomous_change_i(aut_i), .ltssm_l0s_exit_i(l0s_i), .ltssm_recovery_i(rec_i),
    .unreliable_i(unr_i), .width_reconfig_i(wrc_i), .extra_ordered_set_enable_o(eos),
    .send_extra_sets_o(sxs), .width_reduce_o(wred), .width_reconfig_o(wrec),
    .bw_mgmt_irq_o(bwirq), .autonomous_bw_irq_o(abwirq), .irq_o(irq));

  always #5 clk_i = ~clk_i;

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      num_errors++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(LCU_ADDR_CTRL, LCU_CTRL_RESET);
    chk(16'(wred), 16'h0000);
    chk(16'(wrec), 16'h0000);
    wr(4'h2, 16'hffff);
    rd(4'h2, 16'h0000);
    wr(LCU_ADDR_CTRL, 16'hff80);
    rd(LCU_ADDR_CTRL, 16'h0c80);
    chk(16'(sxs), 16'h0000);
    @(posedge clk_i);
    l0s_i <= 1'b1;
    unr_i <= 1'b1;
    wrc_i <= 1'b1;
    #1 chk(16'(sxs), 16'h0001);
    chk(16'(wred), 16'h0001);
    chk(16'(wrec), 16'h0001);
    @(posedge clk_i);
    l0s_i <= 1'b0;
    rec_i <= 1'b1;
    #1 chk(16'(sxs), 16'h0001);
    wr(LCU_ADDR_CTRL, 16'h0c00);
    chk(16'(sxs), 16'h0000);
    @(posedge clk_i);
    ldn_i <= 1'b1;
    rtr_i <= 1'b1;
    @(posedge clk_i);
    rtr_i <= 1'b0;
    ldn_i <= 1'b0;
    rd(LCU_ADDR_STATUS, 16'h0000);
    @(posedge clk_i);
    rtr_i <= 1'b1;
    @(posedge clk_i);
    rtr_i <= 1'b0;
    rd(LCU_ADDR_STATUS, 16'h4000);
    chk(16'(bwirq), 16'h0001);
    rd(LCU_ADDR_IRQ_ST, 16'h0001);
    chk(16'(irq), 16'h0000);
    wr(LCU_ADDR_IRQ_MSK, 16'h0003);
    chk(16'(irq), 16'h0001);
    wr(LCU_ADDR_STATUS, 16'h4000);
    chk(16'(bwirq), 16'h0000);
    wr(LCU_ADDR_IRQ_ST, 16'h0001);
    chk(16'(irq), 16'h0000);
    @(posedge clk_i);
    aut_i <= 1'b1;
    @(posedge clk_i);
    aut_i <= 1'b0;
    rd(LCU_ADDR_STATUS, 16'h8000);
    chk(16'(abwirq), 16'h0001);
    rd(LCU_ADDR_IRQ_ST, 16'h0002);
    chk(16'(irq), 16'h0001);
    wr(LCU_ADDR_CTRL, 16'h0000);
    chk(16'(abwirq), 16'h0000);
    @(posedge clk_i);
    cap_i <= 1'b0;
    wr(LCU_ADDR_CTRL, 16'hff80);
    rd(LCU_ADDR_CTRL, 16'h0080);
    rd(LCU_ADDR_STATUS, 16'h0000);
    @(posedge clk_i);
    cap_i <= 1'b1;
    up_i  <= 1'b1;
    wr(LCU_ADDR_CTRL, 16'hff80);
    rd(LCU_ADDR_CTRL, 16'h0080);
    chk(16'(eos), 16'h0001);
    report_and_stop();
  end
endmodule
